// >>> logic/scs_top.sv
// Module: channel-status register bank of the receiver
`timescale 1ns/1ps
module scs_top
  import scs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Recovered sub-frame status bits
  input wire logic cs_valid,
  input wire logic cs_first_channel,
  input wire logic cs_block_start,
  input wire logic cs_bit,
  // Host readback
  input wire logic rd_en,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data_q,
  output logic rd_hit_q,
  // Decoded status
  output logic status_update_flag,
  output logic professional_use_flag,
  output logic copyright_free_flag,
  output logic pre_emphasis_flag,
  output logic [1:0] status_mode_field,
  output logic [7:0] category_field,
  output logic [3:0] source_number_field,
  output logic [1:0] first_subframe_channel,
  output logic [1:0] second_subframe_channel,
  output logic [3:0] sample_rate_code,
  output logic [1:0] clock_accuracy_field,
  output logic max_length_flag,
  output logic [2:0] length_code,
  output logic [3:0] original_rate_code,
  output logic [4:0] sample_length_q
);

  logic bit_valid;
  logic [SCS_CAP_BITS-1:0] cap_word;
  logic cap_done;
  logic [SCS_CAP_BITS-1:0] live_q;
  logic update_q;
  logic [2:0] rd_index;
  logic rd_known;

  // ----------------------------------------
  // Capture
  // ----------------------------------------
  assign bit_valid = cs_valid && cs_first_channel;

  scs_shift #(
    .WIDTH(SCS_CAP_BITS)
  ) u_shift (
    .clk(clk),
    .sys_rst(sys_rst),
    .bit_valid(bit_valid),
    .bit_start(cs_block_start),
    .bit_value(cs_bit),
    .word_q(cap_word),
    .done_q(cap_done)
  );

  // Shadow copy drives the decoded outputs without a read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      live_q <= '0;
    else if (cap_done)
      live_q <= cap_word;
  end

  // ----------------------------------------
  // Field mapping
  // ----------------------------------------
  assign professional_use_flag = live_q[SCS_POS_PRO];
  assign copyright_free_flag = live_q[SCS_POS_CPY];
  assign pre_emphasis_flag = live_q[SCS_POS_EMPH];
  assign status_mode_field = live_q[SCS_POS_MODE +: 2];
  assign category_field = live_q[SCS_POS_CAT +: 8];
  assign source_number_field = live_q[SCS_POS_SRC +: 4];
  assign first_subframe_channel = live_q[SCS_POS_CH1 +: 2];
  assign second_subframe_channel = live_q[SCS_POS_CH2 +: 2];
  assign sample_rate_code = live_q[SCS_POS_SAMPLE_RATE_CODE +: 4];
  assign clock_accuracy_field = live_q[SCS_POS_ACC +: 2];
  assign max_length_flag = live_q[SCS_POS_MAX_LENGTH_FLAG];
  assign length_code = live_q[SCS_POS_LEN +: 3];
  assign original_rate_code = live_q[SCS_POS_ORIG +: 4];

  // Capture bits already sit in register order: bit 1 non-audio, bits 5:4 reserved
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sample_length_q <= SCS_LEN_UNKNOWN;
    else
      sample_length_q <= scs_len_decode(max_length_flag, length_code);
  end

  // ----------------------------------------
  // Register store and readback
  // ----------------------------------------
  always_comb
  begin
    rd_known = 1'b1;
    rd_index = 3'h0;
    case (rd_addr)
      SCS_ADDR_BYTE0: rd_index = 3'h0;
      SCS_ADDR_CATEGORY: rd_index = 3'h1;
      SCS_ADDR_SRC_CHAN: rd_index = 3'h2;
      SCS_ADDR_SAMPLE_RATE_CODE_ACC: rd_index = 3'h3;
      SCS_ADDR_WORDLEN: rd_index = 3'h4;
      default:
      begin
        rd_known = 1'b0;
        rd_index = 3'h7;
      end
    endcase
  end

  scs_regs u_regs (
    .clk(clk),
    .load(cap_done),
    .load_word(cap_word),
    .rd_index(rd_index),
    .rd_data_q(rd_data_q)
  );

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rd_hit_q <= 1'b0;
    else
      rd_hit_q <= rd_en && rd_known;
  end

  // ----------------------------------------
  // Update flag
  // ----------------------------------------
  // A fresh block wins over a readback in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      update_q <= 1'b0;
    else if (cap_done)
      update_q <= 1'b1;
    else if (rd_en && rd_known)
      update_q <= 1'b0;
  end

  assign status_update_flag = update_q;

endmodule // scs_top

// >>> logic/scs_pkg.sv
// Package: constants and types for the receiver channel-status register bank
package scs_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [6:0] SCS_ADDR_BYTE0 = 7'h2C;
  localparam logic [6:0] SCS_ADDR_CATEGORY = 7'h2D;
  localparam logic [6:0] SCS_ADDR_SRC_CHAN = 7'h2E;
  localparam logic [6:0] SCS_ADDR_SAMPLE_RATE_CODE_ACC = 7'h2F;
  localparam logic [6:0] SCS_ADDR_WORDLEN = 7'h30;

  // ----------------------------------------
  // Block layout
  // ----------------------------------------
  localparam int SCS_CAP_BITS = 40;
  localparam int SCS_BLOCK_FRAMES = 192;
  localparam int SCS_REG_COUNT = 5;
  localparam logic [7:0] SCS_LAST_FRAME = 8'hBF;
  localparam logic [7:0] SCS_LAST_CAP = 8'h27;

  // Field positions inside the 40-bit capture
  localparam int SCS_POS_PRO = 0;
  localparam int SCS_POS_AUDIO_N = 1;
  localparam int SCS_POS_CPY = 2;
  localparam int SCS_POS_EMPH = 3;
  localparam int SCS_POS_RSVD = 4;
  localparam int SCS_POS_MODE = 6;
  localparam int SCS_POS_CAT = 8;
  localparam int SCS_POS_SRC = 16;
  localparam int SCS_POS_CH1 = 20;
  localparam int SCS_POS_CH2 = 22;
  localparam int SCS_POS_SAMPLE_RATE_CODE = 24;
  localparam int SCS_POS_ACC = 28;
  localparam int SCS_POS_MAX_LENGTH_FLAG = 32;
  localparam int SCS_POS_LEN = 33;
  localparam int SCS_POS_ORIG = 36;

  // Reset values of control state
  localparam logic [7:0] SCS_FRAME_RST = 8'h00;
  localparam logic [4:0] SCS_LEN_UNKNOWN = 5'h00;

  typedef enum logic [1:0] {
    SCS_RATE_IGNORE,
    SCS_RATE_LEFT,
    SCS_RATE_RIGHT,
    SCS_RATE_BAD
  } scs_route_t;

  // Decoded sample length in bits; 0 means not indicated or reserved
  function automatic logic [4:0] scs_len_decode(input logic max_flag,
                                                input logic [2:0] code);
    logic [4:0] base;
    base = SCS_LEN_UNKNOWN;
    case (code)
      3'h1: base = 5'h10;
      3'h2: base = 5'h12;
      3'h4: base = 5'h13;
      3'h5: base = 5'h14;
      3'h6: base = 5'h11;
      default: base = SCS_LEN_UNKNOWN;
    endcase
    if (base != SCS_LEN_UNKNOWN && max_flag)
      base = base + 5'h04;
    return base;
  endfunction

endpackage

// >>> logic/scs_shift.sv
// Module: serial capture of the first status bits of a channel-status block
`timescale 1ns/1ps
module scs_shift
  import scs_pkg::*;
#(
  parameter int WIDTH = SCS_CAP_BITS
)(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bit stream
  input wire logic bit_valid,
  input wire logic bit_start,
  input wire logic bit_value,
  // Captured word
  output logic [WIDTH-1:0] word_q,
  output logic done_q
);

  logic [WIDTH-1:0] shift_q;
  logic [7:0] count_q;

  // ----------------------------------------
  // Shift in, LSB (status bit 0) first
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      count_q <= SCS_FRAME_RST;
    else if (bit_valid && bit_start)
      count_q <= 8'h01;
    else if (bit_valid && count_q != SCS_FRAME_RST && count_q <= SCS_LAST_CAP)
      count_q <= count_q + 8'h01;
    else if (bit_valid && count_q > SCS_LAST_CAP)
      count_q <= SCS_FRAME_RST;
  end

  always_ff @(posedge clk)
  begin
    if (bit_valid && bit_start)
      shift_q <= {bit_value, shift_q[WIDTH-1:1]};
    else if (bit_valid && count_q != SCS_FRAME_RST && count_q <= SCS_LAST_CAP)
      shift_q <= {bit_value, shift_q[WIDTH-1:1]};
  end

  // Done once the last captured bit has shifted in
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      done_q <= 1'b0;
    else
      done_q <= bit_valid && !bit_start && count_q == SCS_LAST_CAP;
  end

  always_ff @(posedge clk)
  begin
    // A block start on the last slot restarts the count, so it must not complete a word
    if (bit_valid && !bit_start && count_q == SCS_LAST_CAP)
      word_q <= {bit_value, shift_q[WIDTH-1:1]};
  end

endmodule // scs_shift

// >>> logic/scs_regs.sv
// Module: five-entry read-only status store with registered read data
`timescale 1ns/1ps
module scs_regs
  import scs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Load port
  input wire logic load,
  input wire logic [SCS_CAP_BITS-1:0] load_word,
  // Read port
  input wire logic [2:0] rd_index,
  output logic [7:0] rd_data_q
);

  logic [7:0] mem_q [SCS_REG_COUNT];

  // No reset: contents are undefined until the first block arrives
  always_ff @(posedge clk)
  begin
    if (load)
    begin
      for (int i = 0; i < SCS_REG_COUNT; i++)
        mem_q[i] <= load_word[i*8 +: 8];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rd_index < 3'(SCS_REG_COUNT))
      rd_data_q <= mem_q[rd_index];
    else
      rd_data_q <= 8'h00;
  end

endmodule // scs_regs

// >>> sim/scs_top_chk.sv
// Checker: readback timing and field mapping of the status register bank
`timescale 1ns/1ps
module scs_top_chk
  import scs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Host readback
  input wire logic rd_en,
  input wire logic [6:0] rd_addr,
  input wire logic [7:0] rd_data_q,
  input wire logic rd_hit_q,
  input wire logic status_update_flag,
  // Decoded fields
  input wire logic professional_use_flag,
  input wire logic copyright_free_flag,
  input wire logic pre_emphasis_flag,
  input wire logic [1:0] status_mode_field,
  input wire logic [7:0] category_field,
  input wire logic [3:0] source_number_field,
  input wire logic [1:0] first_subframe_channel,
  input wire logic [1:0] second_subframe_channel,
  input wire logic [3:0] sample_rate_code,
  input wire logic [1:0] clock_accuracy_field,
  input wire logic max_length_flag,
  input wire logic [2:0] length_code,
  input wire logic [3:0] original_rate_code,
  input wire logic [4:0] sample_length_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic hit;
  assign hit = rd_en && rd_addr >= SCS_ADDR_BYTE0 && rd_addr <= SCS_ADDR_WORDLEN;
  // Store keeps old contents over reset while fields clear, so compare only after a load
  logic seen_q;
  logic ok_rd;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      seen_q <= 1'b0;
    else if (status_update_flag)
      seen_q <= 1'b1;
  end
  assign ok_rd = rd_en && (seen_q || status_update_flag);
  a_reset_clears: assert property ($fell(sys_rst) |-> !status_update_flag && !rd_hit_q
    && sample_length_q == 5'h00) else $error("outputs not cleared by reset");
  a_hit_mapped: assert property (hit |=> rd_hit_q) else $error("mapped read not hit");
  a_miss_quiet: assert property (rd_en && !hit |=> rd_data_q == 8'h00 && !rd_hit_q
    && (status_update_flag || !$past(status_update_flag))) else $error("unmapped read");
  a_byte0_map: assert property (ok_rd && rd_addr == SCS_ADDR_BYTE0 |=>
    rd_data_q[0] == $past(professional_use_flag) && rd_data_q[2] == $past(copyright_free_flag)
    && rd_data_q[3] == $past(pre_emphasis_flag) && rd_data_q[7:6] == $past(status_mode_field))
    else $error("byte0 mismatch");
  a_category_map: assert property (ok_rd && rd_addr == SCS_ADDR_CATEGORY |=>
    rd_data_q == $past(category_field)) else $error("category mismatch");
  a_src_chan_map: assert property (ok_rd && rd_addr == SCS_ADDR_SRC_CHAN |=>
    rd_data_q == $past({second_subframe_channel, first_subframe_channel, source_number_field}))
    else $error("source byte mismatch");
  a_sample_rate_code_acc_map: assert property (ok_rd && rd_addr == SCS_ADDR_SAMPLE_RATE_CODE_ACC |=>
    rd_data_q[5:0] == $past({clock_accuracy_field, sample_rate_code})) else $error("sample_rate_code byte");
  a_wordlen_map: assert property (ok_rd && rd_addr == SCS_ADDR_WORDLEN |=>
    rd_data_q == $past({original_rate_code, length_code, max_length_flag}))
    else $error("wordlen byte mismatch");
  c_read_flag: cover property (hit && status_update_flag);
  c_read_miss: cover property (rd_en && !hit);
  c_update: cover property ($rose(status_update_flag));
endmodule // scs_top_chk

bind scs_top scs_top_chk scs_top_chk_inst (.*);

// >>> sim/scs_src.sv
// Partner: source of recovered sub-frame channel-status bits
`timescale 1ns/1ps
module scs_src (
  // Clock
  input wire logic clk,
  // Status bit stream
  output logic cs_valid,
  output logic cs_first_channel,
  output logic cs_block_start,
  output logic cs_bit
);
  initial
  begin
    cs_valid = 1'b0;
    cs_first_channel = 1'b0;
    cs_block_start = 1'b0;
    cs_bit = 1'b0;
  end
  // Each first-channel bit is followed by an inverted second-channel decoy
  task send(input logic [39:0] w, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      cs_valid = 1'b1;
      cs_first_channel = 1'b1;
      cs_block_start = (i == 0);
      cs_bit = w[i];
      @(negedge clk);
      cs_first_channel = 1'b0;
      cs_block_start = 1'b0;
      cs_bit = ~w[i];
      @(negedge clk);
      cs_valid = 1'b0;
      cs_bit = w[i];
    end
  endtask
endmodule // scs_src

// >>> sim/test_scs_top.sv
// Testbench: status register bank fed by a sub-frame status source
`timescale 1ns/1ps
module test_scs_top
  import scs_pkg::*;
;
  logic clk, sys_rst, rd_en, rd_hit_q, status_update_flag;
  logic cs_valid, cs_first_channel, cs_block_start, cs_bit;
  logic [6:0] rd_addr;
  logic [7:0] rd_data_q;
  logic [4:0] sample_length_q;
  logic [39:0] w;
  int bad_count, num_checks;
  // Expected length per row: row index is {length code, max flag}
  logic [4:0] lens [16] = '{5'h00, 5'h00, 5'h10, 5'h14, 5'h12, 5'h16, 5'h00, 5'h00,
    5'h13, 5'h17, 5'h14, 5'h18, 5'h11, 5'h15, 5'h00, 5'h00};
  scs_src scs_src_inst (.clk(clk), .cs_valid(cs_valid), .cs_first_channel(cs_first_channel),
    .cs_block_start(cs_block_start), .cs_bit(cs_bit));
  scs_top scs_top_inst (.clk(clk), .sys_rst(sys_rst), .cs_valid(cs_valid),
    .cs_first_channel(cs_first_channel), .cs_block_start(cs_block_start), .cs_bit(cs_bit),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_hit_q(rd_hit_q),
    .status_update_flag(status_update_flag), .professional_use_flag(),
    .copyright_free_flag(), .pre_emphasis_flag(), .status_mode_field(), .category_field(),
    .source_number_field(), .first_subframe_channel(), .second_subframe_channel(),
    .sample_rate_code(), .clock_accuracy_field(), .max_length_flag(), .length_code(),
    .original_rate_code(), .sample_length_q(sample_length_q));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task tally_and_finish;
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e, input logic h);
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    chk(rd_data_q, e);
    chk(rd_hit_q, h);
  endtask
  task rdall(input logic [39:0] x);
    for (int b = 0; b < 5; b++)
      rd(7'(SCS_ADDR_BYTE0 + b), x[8*b +: 8], 1'b1);
  endtask
  // Bounded wait: a missing update ends the run as a failure
  task wflag;
    int k;
    for (k = 0; k < 50 && status_update_flag !== 1'b1; k++)
      @(negedge clk);
    if (k == 50)
    begin
      bad_count++;
      tally_and_finish;
    end
  endtask
  initial
  begin
    sys_rst = 1'b1;
    rd_en = 1'b0;
    rd_addr = 7'h00;
    bad_count = 0;
    num_checks = 0;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk(status_update_flag, 1'b0);
    chk(sample_length_q, 5'h00);
    for (int r = 0; r < 16; r++)
    begin
      w = {r[3:0] ^ 4'hA, r[3:0], 32'h5A3C96E1 ^ {8{r[3:0]}}};
      scs_src_inst.send(w, 40);
      wflag;
      rd(r[0] ? 7'h31 : 7'h2B, 8'h00, 1'b0);
      chk(status_update_flag, 1'b1);
      rdall(w);
      chk(status_update_flag, 1'b0);
      chk(sample_length_q, lens[r]);
    end
    // Restarted block: partial capture must neither flag nor stick
    scs_src_inst.send(~w, 20);
    chk(status_update_flag, 1'b0);
    scs_src_inst.send(40'hC30F1E2D4B, 40);
    wflag;
    rdall(40'hC30F1E2D4B);
    // Second reset during a capture, with the flag still up
    scs_src_inst.send(w, 40);
    scs_src_inst.send(w, 10);
    chk(status_update_flag, 1'b1);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk({status_update_flag, rd_hit_q, sample_length_q}, 7'h00);
    scs_src_inst.send(40'h0123456789, 40);
    wflag;
    rdall(40'h0123456789);
    tally_and_finish;
  end
endmodule // test_scs_top
